/* rtl/lws_pkg.sv */
// Purpose: Shared constants for the late-write synchronous memory port.
// Assumes: Single clock at 10 MHz; both ends share this package.
// Notes:   Lane width and bus shapes are defaults; modules may override.
package lws_pkg;
    localparam int LWS_LANE_BITS     = 9;
    localparam int LWS_LANES         = 4;
    localparam int LWS_DATA_BITS     = LWS_LANE_BITS * LWS_LANES;
    localparam int LWS_ADDR_BITS     = 17;
    localparam int LWS_CLK_HZ        = 10_000_000;
    localparam int LWS_DWELL_US      = 1000;
    localparam int LWS_DWELL_CYC     = (LWS_DWELL_US * (LWS_CLK_HZ / 1_000_000));
    localparam int LWS_CNT_BITS      = 16;
endpackage

/* rtl/lws_if.sv */
// Purpose: Pin bundle between the memory controller and the memory device.
// Assumes: Data bus is shared; level resolved from the two enables.
// Notes:   Active-low pins are named with _n.
`timescale 1ns/1ps
interface lws_if
    import lws_pkg::*;
#(
    parameter int AW = LWS_ADDR_BITS,
    parameter int LB = LWS_LANE_BITS,
    parameter int NL = LWS_LANES
);
    logic [AW-1:0]    addr;
    logic             sel_n;
    logic             write_n;
    logic [NL-1:0]    lane_write_n;
    logic             out_en_n;
    logic             sleep_pin;
    logic [NL*LB-1:0] dq_ctl;
    logic             dq_ctl_oe;
    logic [NL*LB-1:0] dq_mem;
    logic             dq_mem_oe;
    logic [NL*LB-1:0] dq;

    // Resolved bus level; device wins if both drive
    assign dq = dq_mem_oe ? dq_mem : (dq_ctl_oe ? dq_ctl : '0);

    modport ctl (output addr, output sel_n, output write_n, output lane_write_n,
                 output out_en_n, output sleep_pin, output dq_ctl, output dq_ctl_oe,
                 input dq);
    modport mem (input addr, input sel_n, input write_n, input lane_write_n,
                 input out_en_n, input sleep_pin, output dq_mem, output dq_mem_oe,
                 input dq);
endinterface // lws_if

/* rtl/lws_mem.sv */
// Purpose: Device end: pipelined static memory with late write buffer.
// Assumes: Controller keeps deselect-before-write spacing and power-up dwell.
// Notes:   Output enable gating is combinational by nature of the pin.
`timescale 1ns/1ps
// What this block does, and what it assumes of the controller
// R1: Sample controls on every rising clock edge
// R2: Read data registered next edge, pipelined
// R3: Controller inserts deselect before any write
// R4: Read directly after write is accepted
// R5: Deselect turns drivers off after next edge
// R6: Write input low turns drivers off immediately
// R7: Read select enables drivers after next edge
// R8: Output enable gates drivers asynchronously
// R9: Each lane spans nine data bits
// R10: Lane enables ignored on reads
// R11: All lanes low writes whole word
// R12: Any write suppresses read of all lanes
// R13: Write with no lanes stores nothing, deselects
// R14: Write data sampled one edge after address
// R15: Single write buffer with address-match forwarding
// R16: Controller waits dwell time before operation
// R17: Controller never toggles controls faster than clock
// R18: Read cycle returns all lanes next edge
// R19: Lane a..d map to bits 0-8..27-35
// R20: Full write spans all thirty-six bits
// R21: Word 36 bits four lanes, 17 address
module lws_mem
    import lws_pkg::*;
#(
    parameter int AW = LWS_ADDR_BITS, // R21
    parameter int LB = LWS_LANE_BITS,
    parameter int NL = LWS_LANES
)(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    lws_if.mem        bus
);
    localparam int DW = NL * LB;

    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // Stage registers for address/control
    logic          rd_q,      rd_d;
    logic          wr_q,      wr_d;
    logic [AW-1:0] wa_q,      wa_d;
    logic [NL-1:0] wl_q,      wl_d;
    // Single-stage write buffer
    logic          bv_q,      bv_d;
    logic [AW-1:0] ba_q,      ba_d;
    logic [NL-1:0] bl_q,      bl_d;
    logic [DW-1:0] bd_q,      bd_d;
    // Output register and registered drive
    logic [DW-1:0] dout_q,    dout_d;
    logic          drv_q,     drv_d;
    logic          commit;
    logic          wr_now;

    // Merge lanes from new data over an old word
    function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
                                                input logic [DW-1:0] new_w,
                                                input logic [NL-1:0] lanes);
        logic [DW-1:0] r;
        r = old_w;
        for (int i = 0; i < NL; i++) begin
            if (lanes[i]) begin
                r[i*LB +: LB] = new_w[i*LB +: LB]; // R9 R19
            end
        end
        return r;
    endfunction

    assign wr_now = !bus.sleep_pin && !bus.sel_n && !bus.write_n;

    // Next-state computation for pipeline, buffer and output
    always_comb begin
        rd_d   = !bus.sleep_pin && !bus.sel_n && bus.write_n; // R1 R4 R10 R18
        wr_d   = wr_now;                                      // R1 R12
        wa_d   = bus.addr;                                    // R14
        wl_d   = bus.lane_write_n == '1 ? '0 : ~bus.lane_write_n; // R11 R13 R20
        commit = 1'b0;
        bv_d   = bv_q;
        ba_d   = ba_q;
        bl_d   = bl_q;
        bd_d   = bd_q;
        dout_d = dout_q;
        // Data of write registered last edge is taken now into the buffer
        if (wr_q) begin
            commit = bv_q;                                    // Older entry retires
            bv_d   = (wl_q != '0);                            // R13
            ba_d   = wa_q;
            bl_d   = wl_q;
            bd_d   = bus.dq;                                  // R14
        end
        // Read of registered address, forwarding from buffer on match
        if (rd_q) begin
            dout_d = mem_q[wa_q];                             // R2
            if (bv_q && ba_q == wa_q) begin
                dout_d = lane_merge(mem_q[wa_q], bd_q, bl_q); // R15
            end
        end
        // Drivers: deselect/read effective after next edge; write kills at once
        drv_d = rd_q;                                         // R5 R7
        if (bus.sleep_pin) begin
            drv_d = 1'b0;
        end
    end

    // Pipeline registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
            wa_q   <= '0;
            wl_q   <= '0;
            bv_q   <= 1'b0;
            ba_q   <= '0;
            bl_q   <= '0;
            bd_q   <= '0;
            dout_q <= '0;
            drv_q  <= 1'b0;
        end else begin
            rd_q   <= rd_d;
            wr_q   <= wr_d;
            wa_q   <= wa_d;
            wl_q   <= wl_d;
            bv_q   <= bv_d;
            ba_q   <= ba_d;
            bl_q   <= bl_d;
            bd_q   <= bd_d;
            dout_q <= dout_d;
            drv_q  <= drv_d;
        end
    end

    // Retire buffered write into the array (no reset on memory content)
    always_ff @(posedge clk_i) begin
        if (!sys_rst_i && commit) begin
            mem_q[ba_q] <= lane_merge(mem_q[ba_q], bd_q, bl_q); // R15
        end
    end

    // Output drive: registered enable, killed by write input and output enable
    assign bus.dq_mem    = dout_q;
    assign bus.dq_mem_oe = drv_q && !wr_now && !wr_q && !bus.out_en_n; // R6 R8 R12
endmodule // lws_mem

/* rtl/lws_ctl.sv */
// Purpose: Controller end: issues reads and late writes to the memory.
// Assumes: One request at a time on the user side; reset starts the dwell.
// Notes:   A write is preceded by one deselect cycle automatically.
`timescale 1ns/1ps
module lws_ctl
    import lws_pkg::*;
#(
    parameter int AW    = LWS_ADDR_BITS,
    parameter int LB    = LWS_LANE_BITS,
    parameter int NL    = LWS_LANES,
    parameter int DWELL = LWS_DWELL_CYC
)(
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             req_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    addr_i,
    input  wire logic [NL*LB-1:0] wdata_i,
    input  wire logic [NL-1:0]    lanes_i,
    output logic                  ready_o,
    output logic                  rvalid_o,
    output logic [NL*LB-1:0]      rdata_o,
    lws_if.ctl                    bus
);
    localparam int DW = NL * LB;

    typedef enum logic [4:0] {
        LC_DWELL = 5'h01,
        LC_IDLE  = 5'h02,
        LC_DESEL = 5'h04,
        LC_WADDR = 5'h08,
        LC_WDATA = 5'h10
    } lws_ctl_state_type;

    lws_ctl_state_type st_q, st_d;
    logic [LWS_CNT_BITS-1:0] cnt_q, cnt_d;
    logic [AW-1:0]  a_q,  a_d;
    logic [DW-1:0]  wd_q, wd_d;
    logic [NL-1:0]  ln_q, ln_d;
    logic           sel_q, sel_d, wrn_q, wrn_d, oe_q, oe_d;
    logic [NL-1:0]  lwn_q, lwn_d;
    logic [2:0]     rp_q, rp_d;
    logic           doe_q, doe_d;
    logic           rdy_q, rdy_d, rv_q, rv_d;
    logic [DW-1:0]  rd_q, rd_d;

    // Sequencer next state
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        a_d   = a_q;
        wd_d  = wd_q;
        ln_d  = ln_q;
        sel_d = 1'b0;
        wrn_d = 1'b1;
        lwn_d = '1;
        oe_d  = rp_q[0] | rp_q[1];                            // Hold enable until drive cycle ends
        rdy_d = 1'b0;
        rp_d  = {rp_q[1:0], 1'b0};
        rv_d  = rp_q[2];
        rd_d  = rp_q[2] ? bus.dq : rd_q;                      // R2 R18
        // Data bus driven in the cycle after the write pins are sampled
        doe_d = (st_q == LC_WDATA);                           // R14
        case (st_q)
            LC_DWELL: begin
                cnt_d = cnt_q + 1'b1;                         // R16
                if (cnt_q >= LWS_CNT_BITS'(DWELL - 1)) begin
                    st_d  = LC_IDLE;
                    rdy_d = 1'b1;
                end
            end
            LC_IDLE: begin
                rdy_d = 1'b1;
                if (req_i && rdy_q) begin
                    a_d  = addr_i;
                    wd_d = wdata_i;
                    ln_d = lanes_i;
                    if (we_i) begin
                        st_d  = LC_DESEL;                     // R3
                        rdy_d = 1'b0;
                    end else begin
                        sel_d = 1'b1;                         // R4 R10
                        lwn_d = ~lanes_i;                     // R10
                        oe_d  = 1'b1;
                        rp_d[0] = 1'b1;
                    end
                end
            end
            LC_DESEL: begin
                st_d = LC_WADDR;                              // R3 R17
            end
            LC_WADDR: begin
                sel_d = 1'b1;
                wrn_d = 1'b0;
                lwn_d = ~ln_q;                                // R11
                st_d  = LC_WDATA;
            end
            LC_WDATA: begin
                st_d  = LC_IDLE;                              // R14
                rdy_d = 1'b1;
            end
            default: begin
                st_d = LC_DWELL;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q  <= LC_DWELL;
            cnt_q <= '0;
            a_q   <= '0;
            wd_q  <= '0;
            ln_q  <= '0;
            sel_q <= 1'b0;
            wrn_q <= 1'b1;
            lwn_q <= '1;
            oe_q  <= 1'b0;
            rp_q  <= '0;
            rdy_q <= 1'b0;
            rv_q  <= 1'b0;
            rd_q  <= '0;
            doe_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            a_q   <= a_d;
            wd_q  <= wd_d;
            ln_q  <= ln_d;
            sel_q <= sel_d;
            wrn_q <= wrn_d;
            lwn_q <= lwn_d;
            oe_q  <= oe_d;
            rp_q  <= rp_d;
            rdy_q <= rdy_d;
            rv_q  <= rv_d;
            rd_q  <= rd_d;
            doe_q <= doe_d;
        end
    end

    // Pins from flops, sleep pin tied low; write data driven the cycle after the write address
    assign bus.addr         = a_q;                            // R1
    assign bus.sel_n        = ~sel_q;
    assign bus.write_n      = wrn_q;
    assign bus.lane_write_n = lwn_q;
    assign bus.out_en_n     = ~oe_q;
    assign bus.sleep_pin    = 1'b0;
    assign bus.dq_ctl       = wd_q;
    assign bus.dq_ctl_oe    = doe_q;                          // R14
    assign ready_o          = rdy_q;
    assign rvalid_o         = rv_q;
    assign rdata_o          = rd_q;
endmodule // lws_ctl

/* testbench/lws_properties.sv */
// Purpose: Pin-level checks on the link between controller and memory.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Watches only signals carried by the pin bundle.
`timescale 1ns/1ps
module lws_properties
    import lws_pkg::*;
#(
    parameter int NL = LWS_LANES
)(
    input wire logic          clk_i,
    input wire logic          sys_rst_i,
    input wire logic          sel_n,
    input wire logic          write_n,
    input wire logic [NL-1:0] lane_write_n,
    input wire logic          out_en_n,
    input wire logic          sleep_pin,
    input wire logic          dq_ctl_oe,
    input wire logic          dq_mem_oe
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // Cycle kinds as sampled at one edge
    sequence s_read;
        !sel_n && write_n && !sleep_pin;
    endsequence
    sequence s_write;
        !sel_n && !write_n;
    endsequence
    sequence s_lane_write;
        !sel_n && !write_n && !(&lane_write_n);
    endsequence

    a_oe_async_off: assert property (out_en_n |-> !dq_mem_oe)
        else $error("device drives with output enable off");
    a_write_now_off: assert property (!write_n |-> !dq_mem_oe)
        else $error("device drives while write is low");
    a_read_drives: assert property (s_read |-> ##2 (dq_mem_oe || out_en_n || !write_n))
        else $error("read did not turn drivers on after next edge");
    a_desel_off: assert property (sel_n |-> ##2 !dq_mem_oe)
        else $error("deselect left drivers on");
    a_wdata_cycle: assert property (s_lane_write |=> dq_ctl_oe && !dq_mem_oe)
        else $error("write data not driven one edge after address");
    a_abort_quiet: assert property (s_write |=> !dq_mem_oe)
        else $error("device drove in cycle after a write");
    a_dead_cycle: assert property (s_write |-> $past(sel_n))
        else $error("write without a preceding deselect");
    a_no_clash: assert property (!(dq_ctl_oe && dq_mem_oe))
        else $error("both ends drive the data bus");
endmodule // lws_properties

/* testbench/sync_late_write_sram_port_tb.sv */
// Purpose: Drives the controller user side and checks words read back.
// Assumes: Controller and memory joined through the pin bundle.
// Notes:   Dwell shortened to 4 cycles; four addresses exercised.
`timescale 1ns/1ps
module sync_late_write_sram_port_tb
    import lws_pkg::*;
;
    localparam int DW = LWS_DATA_BITS;
    logic                     clk_i;
    logic                     sys_rst_i;
    logic                     req_i;
    logic                     we_i;
    logic [LWS_ADDR_BITS-1:0] addr_i;
    logic [DW-1:0]            wdata_i;
    logic [LWS_LANES-1:0]     lanes_i;
    logic                     ready_o;
    logic                     rvalid_o;
    logic [DW-1:0]            rdata_o;
    logic [DW-1:0]            model_q [4];
    logic [LWS_ADDR_BITS-1:0] addr_tab [4];
    int                       err_count;
    int                       n_compared;

    lws_if i_lws_if ();
    lws_ctl #(.DWELL(4)) i_lws_ctl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
        .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .lanes_i(lanes_i), .ready_o(ready_o),
        .rvalid_o(rvalid_o), .rdata_o(rdata_o), .bus(i_lws_if.ctl));
    lws_mem i_lws_mem (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(i_lws_if.mem));
    lws_properties i_lws_properties (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .sel_n(i_lws_if.sel_n), .write_n(i_lws_if.write_n),
        .lane_write_n(i_lws_if.lane_write_n), .out_en_n(i_lws_if.out_en_n),
        .sleep_pin(i_lws_if.sleep_pin), .dq_ctl_oe(i_lws_if.dq_ctl_oe),
        .dq_mem_oe(i_lws_if.dq_mem_oe));

    // 100 ns clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask

    task automatic results();
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Bounded wait for ready (rd=0) or read valid (rd=1)
    task automatic wait_flag(input bit rd);
        int k;
        for (k = 0; k < 40; k++) begin
            @(negedge clk_i);
            if ((rd ? rvalid_o : ready_o) === 1'b1) break;
        end
        if (k == 40) begin
            err_count++;
            results();
        end
    endtask

    // Bits covered by the chosen lanes
    function automatic logic [DW-1:0] lmask(input logic [LWS_LANES-1:0] l);
        lmask = '0;
        for (int i = 0; i < LWS_LANES; i++) begin
            if (l[i]) lmask[i*LWS_LANE_BITS +: LWS_LANE_BITS] = '1;
        end
    endfunction

    function automatic logic [DW-1:0] rnd();
        logic [63:0] w;
        w = {$urandom(), $urandom()};
        rnd = w[DW-1:0];
    endfunction

    // One request, taken at the edge after it is placed; reads compared to the model
    task automatic issue(input int j, input bit we, input logic [DW-1:0] d,
                         input logic [LWS_LANES-1:0] l);
        wait_flag(1'b0);
        @(posedge clk_i);
        req_i   <= 1'b1;
        we_i    <= we;
        addr_i  <= addr_tab[j];
        wdata_i <= d;
        lanes_i <= l;
        @(posedge clk_i);
        req_i <= 1'b0;
        if (we) begin
            model_q[j] = (model_q[j] & ~lmask(l)) | (d & lmask(l));
        end else begin
            wait_flag(1'b1);
            check("read word", rdata_o, model_q[j]);
        end
    endtask

    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        req_i = 1'b0;
        we_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        lanes_i = '0;
        err_count = 0;
        n_compared = 0;
        addr_tab = '{17'h00000, 17'h00001, 17'h0aaaa, 17'h1ffff};
        void'($urandom(32'h2e5a));
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Whole words, each read straight after its write with odd lane levels
        for (int j = 0; j < 4; j++) begin
            issue(j, 1'b1, rnd(), '1);
            issue(j, 1'b0, '0, LWS_LANES'(j));
        end
        // Every single lane, then an abort write with no lanes
        for (int i = 0; i < LWS_LANES; i++) begin
            issue(1, 1'b1, rnd(), LWS_LANES'(1 << i));
            issue(1, 1'b0, '0, '1);
        end
        issue(2, 1'b1, rnd(), '0);
        issue(2, 1'b0, '0, '0);
        // Random mix over the four addresses
        repeat (60) begin
            issue(int'($urandom_range(3)), 1'($urandom_range(1)), rnd(), LWS_LANES'($urandom));
        end
        for (int j = 0; j < 4; j++) issue(j, 1'b0, '0, '1);
        results();
    end
endmodule // sync_late_write_sram_port_tb
